// ==== rtl/ibb_bridge.sv ====
`timescale 1ns/1ps
module ibb_bridge #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk, // 25 MHz clock
	input wire logic reset, // async reset, high
	input wire logic adapter_reset_n, // adapter reset, low
	input wire logic power_on_good, // power good, low resets
	input wire logic backplane_power_on_request, // power-on from buffer board
	input wire logic msg_avail, // message waiting on link
	output logic msg_req, // request message word
	input wire ibb_pkg::ibb_link_in_s link_in, // inbound link word pair
	input wire logic link_in_valid, // inbound pair valid
	output ibb_pkg::ibb_link_out_s link_out, // outbound link word pair
	output logic link_out_valid, // outbound pair valid
	input wire logic link_out_ready, // buffer board takes pair
	input wire ibb_pkg::ibb_bp_in_s bp_in, // raw backplane inputs
	output logic [15:0] bp_addr_out, // backplane address lines
	output logic bp_addr_oe, // address lines driven
	output logic [15:0] bp_data_out, // backplane data lines
	output logic bp_data_oe, // data lines driven
	output logic bp_cmd_strobe, // master command strobe
	output logic bp_global, // command is global
	output logic bp_bus_req, // backplane ownership request
	output logic bp_addr_ack, // slave address acknowledge
	output logic bp_data_ack, // slave data acknowledge
	output logic bp_parity_err, // memory read data parity error
	output logic bp_reset_out, // backplane clear pulse
	output logic bp_power_on, // backplane power-on
	output logic busy // controller not idle
);
	import ibb_pkg::*;
	localparam int BPW = $bits(ibb_bp_in_s);

	logic [1:0] rst_q;
	logic rst;
	logic [BPW-1:0] s1_q, s2_q, s3_q, f_q;
	ibb_bp_in_s bp_s;
	ibb_state_e state_q, state_d;
	logic [15:0] w0_q, w1_q, tc_q, mar_q, bpd_q;
	logic p0_q, p1_q, mar_par_q, mem_wr_q, aack_q, dack_q, perr_q, pon_q, clr_pend_q;
	logic [7:0] ext_a_q, ext_b_q;
	logic [2:0] stat_q;
	logic [9:0] cnt_q;
	logic [1:0] clr_cnt_q;

	// Any of the three reset sources resets at once; release is held for two clocks.
	wire raw_rst = reset || !adapter_reset_n || !power_on_good;
	always_ff @(posedge clk or posedge raw_rst) begin
		if (raw_rst)
			rst_q <= 2'h3;
		else
			rst_q <= {rst_q[0], 1'b0};
	end
	assign rst = rst_q[1];

	// The first stage feeds only the second; a bit changes when stages two and three agree.
	genvar b;
	generate
		for (b = 0; b < BPW; b++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_q[b] <= 1'b0;
					s2_q[b] <= 1'b0;
					s3_q[b] <= 1'b0;
					f_q[b] <= 1'b0;
				end else begin
					s1_q[b] <= bp_in[b];
					s2_q[b] <= s1_q[b];
					s3_q[b] <= s2_q[b];
					if (s2_q[b] == s3_q[b])
						f_q[b] <= s3_q[b];
				end
			end
		end
	endgenerate
	assign bp_s = f_q;

	// Command decode on the word-0 buffer.
	wire cmd_read = w0_q[CMD_READ_BIT];
	wire cmd_global = w0_q[CMD_GLOBAL_BIT];
	wire cmd_local = !cmd_global && w0_q[CMD_CHAN_LSB +: 4] == 4'h0
		&& w0_q[CMD_DEV_LSB +: 3] == 3'h0;
	wire [1:0] reg_sel = w0_q[CMD_REG_LSB +: 2];
	wire cmd_perr = (p0_q != par_n_of(w0_q)) || (p1_q != par_n_of(w1_q));
	wire irq_on = bp_s.irq && tc_q[TC_IRQ_MASK_BIT];
	wire csrq_on = bp_s.channel_service_request && tc_q[TC_CSRQ_MASK_BIT];
	wire int_pend = irq_on || csrq_on;
	wire in_idle = (state_q == ST_IDLE);
	wire mem_go = in_idle && !msg_avail && bp_s.addr_strobe;
	wire int_go = in_idle && !msg_avail && !bp_s.addr_strobe && int_pend;
	wire m2_timeout = !cmd_global && !bp_s.cmd_reply && cnt_q == 10'(TIMEOUT_CYCLES);
	wire m2_global_end = cmd_global && cnt_q == 10'(GLOBAL_CMD_CYCLES - 1);
	wire m2_done = m2_global_end || (!cmd_global && bp_s.cmd_reply) || m2_timeout;
	wire reg_write = (state_q == ST_L) && !cmd_read;
	wire s2_wr_take = (state_q == ST_S2) && mem_wr_q && bp_s.data_strobe;
	wire s2_rd_take = (state_q == ST_S2) && !mem_wr_q && link_in_valid;
	wire s3_exit = (state_q == ST_S3) && dack_q && !bp_s.data_strobe && !bp_s.addr_strobe;

	// Register read path: registers 0, 1 and 3 by the outbound data bus, 2 by the internal bus.
	wire [15:0] dbus_reg = (reg_sel == REG_TEST_CONTROL) ? tc_q :
		(reg_sel == REG_EXT_ADDR) ? {8'h00, ext_b_q} : bpd_q;
	wire [15:0] reg_rd = (reg_sel == REG_MEM_ADDR) ? mar_q : dbus_reg;
	wire [15:0] resp_w1 = cmd_local ? reg_rd : bpd_q;
	wire in_mem = (state_q == ST_S1) || (state_q == ST_S2);
	wire [7:0] xbus = in_mem ? ext_a_q : {5'h00, stat_q};

	logic push_valid;
	logic push_ready;
	ibb_kind_e push_kind;
	logic [15:0] push_w0, push_w1;
	ibb_link_out_s push_word;

	always_comb begin
		push_valid = 1'b0;
		push_kind = KIND_RESPONSE;
		push_w0 = {xbus, 8'h00};
		push_w1 = resp_w1;
		if (state_q == ST_W) begin
			push_valid = 1'b1;
		end else if (state_q == ST_X1) begin
			push_valid = 1'b1;
			push_kind = KIND_UNSOLICITED;
			push_w1 = {14'h0000, csrq_on, irq_on};
		end else if (state_q == ST_S1) begin
			push_valid = 1'b1;
			push_kind = mem_wr_q ? KIND_ADDR_WRITE : KIND_ADDR_READ;
			push_w1 = mar_q;
		end else if (s2_wr_take) begin
			push_valid = 1'b1;
			push_kind = KIND_WRITE_DATA;
			push_w0 = bp_s.data;
			push_w1 = bp_s.data;
		end
	end

	// Outbound parity is generated only; address parity was made when the address was stored.
	assign push_word.kind = push_kind;
	assign push_word.link_word0_bits = push_w0;
	assign push_word.link_word1_bits = push_w1;
	assign push_word.link_parity_word0_n = par_n_of(push_w0);
	assign push_word.link_parity_word1_n = (state_q == ST_S1) ? mar_par_q :
		par_n_of(push_w1);

	ibb_fifo #(
		.WIDTH($bits(ibb_link_out_s)),
		.DEPTH(FIFO_DEPTH)
	) u_out_fifo (
		.clk(clk),
		.reset(rst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_word),
		.out_valid(link_out_valid),
		.out_ready(link_out_ready),
		.out_data(link_out)
	);

	// Priority from idle: CPU message, then memory request, then unsolicited message.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (msg_avail)
					state_d = ST_R1;
				else if (mem_go)
					state_d = ST_S1;
				else if (int_go)
					state_d = ST_X1;
			end
			ST_R1: if (link_in_valid) state_d = ST_R2;
			ST_R2: state_d = cmd_perr ? ST_W : (cmd_local ? ST_L : ST_M1);
			ST_M1: if (bp_s.bus_grant) state_d = ST_M2;
			ST_M2: if (m2_done) state_d = ST_W;
			ST_L: state_d = ST_W;
			ST_W: if (push_ready) state_d = ST_IDLE;
			ST_X1: if (push_ready) state_d = ST_X2;
			ST_X2: state_d = ST_IDLE;
			ST_S1: if (push_ready) state_d = ST_S2;
			ST_S2: if ((s2_wr_take && push_ready) || s2_rd_take) state_d = ST_S3;
			ST_S3: if (s3_exit) state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Link buffers keep the received parity pins for later checking.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			w0_q <= 16'h0000;
			w1_q <= 16'h0000;
			p0_q <= 1'b0;
			p1_q <= 1'b0;
		end else if ((state_q == ST_R1 && link_in_valid) || s2_rd_take) begin
			w0_q <= link_in.link_word0_bits;
			w1_q <= link_in.link_word1_bits;
			p0_q <= link_in.link_parity_word0_n;
			p1_q <= link_in.link_parity_word1_n;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mar_q <= 16'h0000;
			mar_par_q <= 1'b0;
			ext_a_q <= 8'h00;
			ext_b_q <= 8'h00;
			mem_wr_q <= 1'b0;
		end else if (mem_go) begin
			mar_q <= bp_s.addr;
			mar_par_q <= par_n_of(bp_s.addr);
			ext_a_q <= bp_s.ext_addr;
			ext_b_q <= bp_s.ext_addr;
			mem_wr_q <= bp_s.mem_write;
		end else if (reg_write && reg_sel == REG_MEM_ADDR) begin
			mar_q <= w1_q;
			mar_par_q <= par_n_of(w1_q);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			bpd_q <= 16'h0000;
		else if (s2_wr_take || (state_q == ST_M2 && bp_s.cmd_reply && cmd_read))
			bpd_q <= bp_s.data;
		else if ((state_q == ST_M1 && !cmd_read) || (reg_write && reg_sel == REG_BP_DATA))
			bpd_q <= w1_q;
	end

	// A software write to the control register wins over the mask clear after an unsolicited send.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tc_q <= TC_RESET;
		else if (reg_write && reg_sel == REG_TEST_CONTROL)
			tc_q <= w1_q;
		else if (state_q == ST_X2) begin
			tc_q[TC_IRQ_MASK_BIT] <= 1'b0;
			tc_q[TC_CSRQ_MASK_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			stat_q <= 3'h0;
		else if (in_idle && msg_avail)
			stat_q <= 3'h0;
		else begin
			if (state_q == ST_R2 && cmd_perr)
				stat_q[STAT_PERR_BIT] <= 1'b1;
			if (state_q == ST_M2 && m2_timeout)
				stat_q[STAT_TIMEOUT_BIT] <= 1'b1;
			if (state_q == ST_M2 && bp_s.data_not_valid_flag)
				stat_q[STAT_DNV_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt_q <= 10'h000;
		else if (state_q == ST_M2)
			cnt_q <= cnt_q + 10'h001;
		else
			cnt_q <= 10'h000;
	end

	// Slave handshakes: acks hold until the channel drops both strobes.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aack_q <= 1'b0;
			dack_q <= 1'b0;
			perr_q <= 1'b0;
		end else if (s3_exit) begin
			aack_q <= 1'b0;
			dack_q <= 1'b0;
			perr_q <= 1'b0;
		end else begin
			if (state_q == ST_S1 && push_ready)
				aack_q <= 1'b1;
			if ((s2_wr_take && push_ready) || (state_q == ST_S3 && bp_s.data_strobe))
				dack_q <= 1'b1;
			if (s2_rd_take)
				perr_q <= link_in.link_parity_word0_n
					!= par_n_of(link_in.link_word0_bits);
		end
	end

	// The clear waits for idle so an in-flight response is never cut short.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clr_pend_q <= 1'b0;
			clr_cnt_q <= 2'h0;
		end else begin
			if (reg_write && reg_sel == REG_TEST_CONTROL && w1_q[TC_CLEAR_BIT])
				clr_pend_q <= 1'b1;
			else if (in_idle && clr_pend_q)
				clr_pend_q <= 1'b0;
			if (in_idle && clr_pend_q)
				clr_cnt_q <= 2'(CLEAR_PULSE_CYCLES);
			else if (clr_cnt_q != 2'h0)
				clr_cnt_q <= clr_cnt_q - 2'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pon_q <= 1'b0;
		else
			pon_q <= backplane_power_on_request;
	end

	assign msg_req = (state_q == ST_R1);
	assign bp_bus_req = (state_q == ST_M1) || (state_q == ST_M2);
	assign bp_cmd_strobe = (state_q == ST_M2);
	assign bp_global = (state_q == ST_M2) && cmd_global;
	assign bp_addr_out = w0_q;
	assign bp_addr_oe = (state_q == ST_M2);
	assign bp_data_out = (state_q == ST_S3) ? w0_q : w1_q;
	assign bp_data_oe = (state_q == ST_M2 && !cmd_read) || (state_q == ST_L)
		|| (state_q == ST_S3 && !mem_wr_q);
	assign bp_addr_ack = aack_q;
	assign bp_data_ack = dack_q;
	assign bp_parity_err = perr_q;
	assign bp_reset_out = (clr_cnt_q != 2'h0);
	assign bp_power_on = pon_q;
	assign busy = !in_idle;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_fetch;
		state_q == ST_R1 && link_in_valid;
	endsequence
	sequence s_clear_pulse;
		bp_reset_out [*3] ##1 !bp_reset_out;
	endsequence

	a_clear_pulse_len: assert property ($rose(bp_reset_out) |-> s_clear_pulse)
		else $error("clear pulse not three clocks");
	a_timeout_end: assert property (
		state_q == ST_M2 && m2_timeout |=> state_q == ST_W && stat_q[STAT_TIMEOUT_BIT])
		else $error("timeout did not end handshake");
	a_timeout_bound: assert property (
		state_q == ST_M2 && !cmd_global && !bp_s.cmd_reply && cnt_q != 10'd1023
		|=> state_q == ST_M2)
		else $error("handshake ended before timeout");
	a_global_end: assert property (
		state_q == ST_M2 && cmd_global && cnt_q == 10'd24 |=> state_q == ST_W)
		else $error("global command not ended after 1 us");
	a_local_register: assert property (
		s_fetch ##1 (!cmd_perr && cmd_local) |=> state_q == ST_L)
		else $error("local command not a register operation");
	a_parity_reject: assert property (
		state_q == ST_R2 && cmd_perr |=> state_q == ST_W && stat_q[STAT_PERR_BIT])
		else $error("bad command parity executed");
	a_mask_clear: assert property (
		state_q == ST_X1 && push_ready ##1 state_q == ST_X2 |=>
		!tc_q[TC_IRQ_MASK_BIT] && !tc_q[TC_CSRQ_MASK_BIT])
		else $error("masks not cleared after unsolicited send");
	a_power_hold: assert property (!backplane_power_on_request |=> !bp_power_on)
		else $error("backplane power-on high without request");
	a_xbus_low_zero: assert property (
		push_valid && push_kind != KIND_WRITE_DATA |-> push_w0[7:0] == 8'h00)
		else $error("link bits 00-07 not zero");
	a_addr_parity: assert property (
		state_q == ST_S1 |-> push_word.link_parity_word1_n == (^mar_q))
		else $error("address parity wrong");
	a_grant_first: assert property ($rose(bp_cmd_strobe) |-> $past(bp_s.bus_grant))
		else $error("command strobe without ownership");
endmodule

// ==== rtl/ibb_pkg.sv ====
package ibb_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int GLOBAL_CMD_NS = 1000;
	localparam int GLOBAL_CMD_CYCLES = GLOBAL_CMD_NS / CLK_PERIOD_NS;
	localparam int TIMEOUT_CYCLES = 1023;
	localparam int CLEAR_PULSE_CYCLES = 3;
	localparam logic [1:0] REG_TEST_CONTROL = 2'h0;
	localparam logic [1:0] REG_EXT_ADDR = 2'h1;
	localparam logic [1:0] REG_MEM_ADDR = 2'h2;
	localparam logic [1:0] REG_BP_DATA = 2'h3;
	localparam logic [15:0] TC_RESET = 16'h0000;
	localparam int TC_IRQ_MASK_BIT = 0;
	localparam int TC_CSRQ_MASK_BIT = 1;
	// Link bit 22 lands on bit 6 of the word-1 buffer.
	localparam int TC_CLEAR_BIT = 6;
	localparam int CMD_READ_BIT = 15;
	localparam int CMD_GLOBAL_BIT = 14;
	localparam int CMD_CHAN_LSB = 10;
	localparam int CMD_DEV_LSB = 7;
	localparam int CMD_REG_LSB = 0;
	localparam int STAT_PERR_BIT = 0;
	localparam int STAT_TIMEOUT_BIT = 1;
	localparam int STAT_DNV_BIT = 2;

	typedef enum logic [2:0] {
		KIND_RESPONSE = 3'h0,
		KIND_UNSOLICITED = 3'h1,
		KIND_ADDR_READ = 3'h2,
		KIND_ADDR_WRITE = 3'h3,
		KIND_WRITE_DATA = 3'h4
	} ibb_kind_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_R1 = 4'h1,
		ST_R2 = 4'h3,
		ST_M1 = 4'h2,
		ST_M2 = 4'h6,
		ST_W = 4'h7,
		ST_L = 4'h5,
		ST_S1 = 4'h4,
		ST_S2 = 4'hc,
		ST_S3 = 4'hd,
		ST_X1 = 4'hf,
		ST_X2 = 4'he
	} ibb_state_e;

	typedef struct packed {
		logic [15:0] link_word0_bits;
		logic [15:0] link_word1_bits;
		logic link_parity_word0_n;
		logic link_parity_word1_n;
	} ibb_link_in_s;

	typedef struct packed {
		ibb_kind_e kind;
		logic [15:0] link_word0_bits;
		logic [15:0] link_word1_bits;
		logic link_parity_word0_n;
		logic link_parity_word1_n;
	} ibb_link_out_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] ext_addr;
		logic [15:0] data;
		logic addr_strobe;
		logic mem_write;
		logic data_strobe;
		logic cmd_reply;
		logic bus_grant;
		logic data_not_valid_flag;
		logic irq;
		logic channel_service_request;
	} ibb_bp_in_s;

	// Active-low odd parity pin level: low when the word has an even count of ones.
	function automatic logic par_n_of(input logic [15:0] x);
		par_n_of = ^x;
	endfunction
endpackage

// ==== rtl/ibb_fifo.sv ====
`timescale 1ns/1ps
module ibb_fifo #(
	parameter int WIDTH = 38,
	parameter int DEPTH = 16
) (
	input wire logic clk, // clock
	input wire logic reset, // async reset, high
	input wire logic in_valid, // write request
	output logic in_ready, // room available
	input wire logic [WIDTH-1:0] in_data, // write word
	output logic out_valid, // word available
	input wire logic out_ready, // reader takes word
	output logic [WIDTH-1:0] out_data // head word
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [CW-1:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW-1:0] wr_inc = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
	wire [AW-1:0] rd_inc = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;

	assign in_ready = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			always_ff @(posedge clk or posedge reset) begin
				if (reset)
					mem_q[i] <= '0;
				else if (push && wr_q == AW'(i))
					mem_q[i] <= in_data;
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_inc;
			if (pop)
				rd_q <= rd_inc;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// ==== testbench/ibb_board_model.sv ====
`timescale 1ns/1ps
module ibb_board_model (
	input wire logic clk, // clock
	input wire logic stall, // holds off the outbound side
	output logic msg_avail, // message waiting
	input wire logic msg_req, // bridge asks for the word
	output ibb_pkg::ibb_link_in_s link_in, // pair toward the bridge
	output logic link_in_valid, // pair valid
	input wire ibb_pkg::ibb_link_out_s link_out, // pair from the bridge
	input wire logic link_out_valid, // pair offered
	output logic link_out_ready // pair accepted
);
	import ibb_pkg::*;
	ibb_link_out_s got[$];
	assign link_out_ready = !stall;
	initial begin
		msg_avail = 1'b0;
		link_in_valid = 1'b0;
		link_in = '0;
	end
	// Accepted pairs queue up so the bench can compare them in order.
	always @(posedge clk) begin
		if (link_out_valid === 1'b1 && link_out_ready) begin
			got.push_back(link_out);
		end
	end
	// Called just after an edge; bad flips the word-0 parity pin.
	task automatic send(input logic [15:0] w0, input logic [15:0] w1, input logic bad);
		int n;
		n = 0;
		msg_avail = 1'b1;
		@(posedge clk);
		#1;
		while (msg_req !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		give(w0, w1, bad);
		msg_avail = 1'b0;
	endtask
	// Offers one pair for a single cycle; used alone for memory read data.
	task automatic give(input logic [15:0] w0, input logic [15:0] w1, input logic bad);
		link_in = '{w0, w1, ^w0 ^ bad, ^w1};
		link_in_valid = 1'b1;
		@(posedge clk);
		#1;
		link_in_valid = 1'b0;
		// A released link must not keep showing the last pair.
		link_in = ~link_in;
	endtask
endmodule

// ==== testbench/ibb_bridge_tb.sv ====
`timescale 1ns/1ps
module ibb_bridge_tb;
	import ibb_pkg::*;
	logic clk, reset, adapter_reset_n, power_on_good, backplane_power_on_request, stall;
	logic msg_avail, msg_req, link_in_valid, link_out_valid, link_out_ready;
	ibb_link_in_s link_in;
	ibb_link_out_s link_out;
	ibb_bp_in_s bp, bp_in;
	logic [15:0] bp_addr_out, bp_data_out;
	logic bp_addr_oe, bp_data_oe, bp_cmd_strobe, bp_global, bp_bus_req, bp_addr_ack;
	logic bp_data_ack, bp_parity_err, bp_reset_out, bp_power_on, busy;
	logic [5:0] obs;
	int n_fail = 0;
	int checks_done = 0;
	logic [15:0] vals [4] = '{16'h0020, 16'h0000, 16'hbeef, 16'h1357};

	// Lines the bridge drives override what the bench puts on them.
	always_comb begin
		bp_in = bp;
		if (bp_data_oe === 1'b1) begin
			bp_in.data = bp_data_out;
		end
		if (bp_addr_oe === 1'b1) begin
			bp_in.addr = bp_addr_out;
		end
	end
	assign obs = {busy, bp_reset_out, bp_data_ack, bp_addr_ack, bp_cmd_strobe, bp_bus_req};

	ibb_bridge #(.FIFO_DEPTH(16)) ibb_bridge_i (.clk(clk), .reset(reset),
		.adapter_reset_n(adapter_reset_n), .power_on_good(power_on_good),
		.backplane_power_on_request(backplane_power_on_request), .msg_avail(msg_avail),
		.msg_req(msg_req), .link_in(link_in), .link_in_valid(link_in_valid),
		.link_out(link_out), .link_out_valid(link_out_valid), .link_out_ready(link_out_ready),
		.bp_in(bp_in), .bp_addr_out(bp_addr_out), .bp_addr_oe(bp_addr_oe),
		.bp_data_out(bp_data_out), .bp_data_oe(bp_data_oe), .bp_cmd_strobe(bp_cmd_strobe),
		.bp_global(bp_global), .bp_bus_req(bp_bus_req), .bp_addr_ack(bp_addr_ack),
		.bp_data_ack(bp_data_ack), .bp_parity_err(bp_parity_err),
		.bp_reset_out(bp_reset_out), .bp_power_on(bp_power_on), .busy(busy));

	ibb_board_model ibb_board_model_i (.clk(clk), .stall(stall), .msg_avail(msg_avail),
		.msg_req(msg_req), .link_in(link_in), .link_in_valid(link_in_valid),
		.link_out(link_out), .link_out_valid(link_out_valid),
		.link_out_ready(link_out_ready));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic complete_run();
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [36:0] exp, input logic [36:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_sig(input int k, input logic v);
		int n;
		n = 0;
		while (obs[k] !== v && n < 2000) begin
			tick(1);
			n++;
		end
		chk(v, obs[k]);
	endtask

	// Mask bit 0 compares word 0, bit 1 compares word 1.
	task automatic expect_out(input ibb_kind_e k, input logic [15:0] w0, input logic [15:0] w1,
			input logic [1:0] m);
		ibb_link_out_s g, e;
		int n;
		n = 0;
		while (ibb_board_model_i.got.size() == 0 && n < 2000) begin
			tick(1);
			n++;
		end
		g = 'x;
		if (ibb_board_model_i.got.size() > 0) begin
			g = ibb_board_model_i.got.pop_front();
		end
		e = '{k, w0, w1, ^w0, ^w1};
		if (!m[0]) begin
			e.link_word0_bits = g.link_word0_bits;
			e.link_parity_word0_n = g.link_parity_word0_n;
		end
		if (!m[1]) begin
			e.link_word1_bits = g.link_word1_bits;
			e.link_parity_word1_n = g.link_parity_word1_n;
		end
		chk(e, g);
	endtask

	task automatic reg_op(input logic [15:0] cmd, input logic [15:0] w1, input logic [15:0] ew1);
		ibb_board_model_i.send(cmd, w1, 1'b0);
		expect_out(KIND_RESPONSE, 16'h0000, ew1, 2'b11);
	endtask

	task automatic bp_cmd(input logic [15:0] cmd, input logic [15:0] w1, input logic reply,
			input logic [15:0] rdata, input logic [15:0] ew0, input logic [15:0] ew1,
			input logic [1:0] m);
		ibb_board_model_i.send(cmd, w1, 1'b0);
		wait_sig(0, 1'b1);
		chk(1'b0, obs[1]);
		bp.bus_grant = 1'b1;
		wait_sig(1, 1'b1);
		chk({cmd, cmd[14], !cmd[15], w1, 1'b1}, {bp_addr_out, bp_global, bp_data_oe, bp_data_out,
			bp_addr_oe});
		bp.data = rdata;
		bp.cmd_reply = reply;
		if (cmd[14]) begin
			tick(24);
			chk(1'b1, obs[1]);
			tick(1);
			chk(1'b0, obs[1]);
		end else if (!reply) begin
			tick(1000);
			chk(1'b1, obs[1]);
		end
		wait_sig(1, 1'b0);
		bp.bus_grant = 1'b0;
		bp.cmd_reply = 1'b0;
		bp.data = ~rdata;
		expect_out(KIND_RESPONSE, ew0, ew1, m);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		complete_run();
	end

	initial begin
		reset = 1'b1;
		adapter_reset_n = 1'b1;
		power_on_good = 1'b1;
		backplane_power_on_request = 1'b1;
		stall = 1'b0;
		bp = '0;
		tick(8);
		chk(3'h0, {link_out_valid, busy, msg_req});
		reset = 1'b0;
		tick(8);
		reg_op(16'h8000, 16'h0000, 16'h0000);
		for (int r = 0; r < 4; r++) begin
			if (r != 1) begin
				reg_op(r[15:0], vals[r], vals[r]);
				reg_op(16'h8000 | r[15:0], 16'h0000, vals[r]);
			end
		end
		ibb_board_model_i.send(16'h8000, 16'h0000, 1'b1);
		expect_out(KIND_RESPONSE, 16'h0100, 16'h0000, 2'b01);
		bp_cmd(16'h0403, 16'habcd, 1'b1, 16'h0000, 16'h0000, 16'habcd, 2'b11);
		bp_cmd(16'h8403, 16'h0000, 1'b1, 16'h5a5a, 16'h0000, 16'h5a5a, 2'b11);
		bp_cmd(16'h4403, 16'h0f0f, 1'b0, 16'h0000, 16'h0000, 16'h0f0f, 2'b11);
		bp.data_not_valid_flag = 1'b1;
		bp_cmd(16'h8403, 16'h0000, 1'b0, 16'h0000, 16'h0600, 16'h0000, 2'b01);
		bp.data_not_valid_flag = 1'b0;
		bp.addr = 16'h2468;
		bp.ext_addr = 8'h9c;
		bp.mem_write = 1'b1;
		tick(3);
		bp.addr_strobe = 1'b1;
		expect_out(KIND_ADDR_WRITE, 16'h9c00, 16'h2468, 2'b11);
		wait_sig(2, 1'b1);
		bp.data = 16'h7531;
		tick(3);
		bp.data_strobe = 1'b1;
		expect_out(KIND_WRITE_DATA, 16'h7531, 16'h7531, 2'b11);
		wait_sig(3, 1'b1);
		bp.addr_strobe = 1'b0;
		bp.data_strobe = 1'b0;
		bp.addr = 16'h5555;
		wait_sig(3, 1'b0);
		chk(1'b0, bp_addr_ack);
		reg_op(16'h8001, 16'h0000, 16'h009c);
		reg_op(16'h8002, 16'h0000, 16'h2468);
		bp.addr = 16'h1234;
		bp.ext_addr = 8'h21;
		bp.mem_write = 1'b0;
		tick(3);
		bp.addr_strobe = 1'b1;
		expect_out(KIND_ADDR_READ, 16'h2100, 16'h1234, 2'b11);
		wait_sig(2, 1'b1);
		ibb_board_model_i.give(16'hc3c3, 16'h0000, 1'b1);
		chk({2'h3, 16'hc3c3}, {bp_data_oe, bp_parity_err, bp_data_out});
		bp.data_strobe = 1'b1;
		wait_sig(3, 1'b1);
		bp.addr_strobe = 1'b0;
		bp.data_strobe = 1'b0;
		wait_sig(3, 1'b0);
		chk(1'b0, bp_parity_err);
		stall = 1'b1;
		repeat (17) begin
			ibb_board_model_i.send(16'h8003, 16'h0000, 1'b0);
			tick(1);
		end
		tick(5);
		chk(3'h6, {link_out_valid, busy, link_out_ready});
		stall = 1'b0;
		repeat (17) expect_out(KIND_RESPONSE, 16'h0000, 16'h7531, 2'b11);
		for (int i = 0; i < 2; i++) begin
			reg_op(16'h0000, 16'h0001 << i, 16'h0001 << i);
			bp.irq = (i == 0);
			bp.channel_service_request = (i == 1);
			expect_out(KIND_UNSOLICITED, 16'h0000, 16'h0001 << i, 2'b10);
			tick(10);
			chk(0, ibb_board_model_i.got.size());
			reg_op(16'h8000, 16'h0000, 16'h0000);
			bp.irq = 1'b0;
			bp.channel_service_request = 1'b0;
		end
		ibb_board_model_i.send(16'h0000, 16'h0040, 1'b0);
		wait_sig(4, 1'b1);
		tick(2);
		chk(1'b1, obs[4]);
		tick(1);
		chk(1'b0, obs[4]);
		expect_out(KIND_RESPONSE, 16'h0000, 16'h0040, 2'b11);
		backplane_power_on_request = 1'b0;
		tick(3);
		chk(1'b0, bp_power_on);
		backplane_power_on_request = 1'b1;
		tick(3);
		chk(1'b1, bp_power_on);
		for (int i = 0; i < 2; i++) begin
			stall = 1'b1;
			ibb_board_model_i.send(16'h8000, 16'h0000, 1'b0);
			tick(3);
			adapter_reset_n = (i != 0);
			power_on_good = (i == 0);
			tick(2);
			chk(2'h0, {link_out_valid, busy});
			adapter_reset_n = 1'b1;
			power_on_good = 1'b1;
			tick(8);
			stall = 1'b0;
			tick(3);
			chk(0, ibb_board_model_i.got.size());
		end
		complete_run();
	end
endmodule
